// ---- core/cs_stretch_pkg.sv ----
package cs_stretch_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_STRETCH = 10'h05a;
  localparam logic [9:0] IDX_GP2_BASE = 10'h05e;
  localparam logic [9:0] IDX_GP2_CTRL = 10'h05f;
  localparam logic [9:0] IDX_MISC = 10'h060;
  localparam logic [9:0] IDX_STATUS = 10'h061;
  localparam logic [11:0] ADDR_STRETCH = {IDX_STRETCH, 2'b00};
  localparam logic [11:0] ADDR_GP2_BASE = {IDX_GP2_BASE, 2'b00};
  localparam logic [11:0] ADDR_GP2_CTRL = {IDX_GP2_CTRL, 2'b00};
  localparam logic [11:0] ADDR_MISC = {IDX_MISC, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  // control register fields
  localparam int CTL_DRV_PROG = 6;
  localparam int CTL_POL = 5;
  localparam int CTL_TIMING = 4;
  localparam int CTL_SIZE_LSB = 0;
  // stretch register fields (low bit of each pair)
  localparam int STR_IO = 6;
  localparam int STR_GP1 = 4;
  localparam int STR_GP2 = 2;
  localparam int STR_PROG = 0;
  // misc register fields
  localparam int MISC_PRIO = 0;
  localparam int MISC_FOLLOW = 1;
  // reset values
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [7:0] BASE_RST = 8'h00;
  localparam logic [7:0] STR_RST = 8'h00;
  localparam logic [1:0] MISC_RST = 2'h0;
  // size codes
  localparam logic [3:0] SZ_OFF = 4'h0;
  localparam logic [3:0] SZ_WIN1 = 4'ha;
  localparam logic [3:0] SZ_WIN2 = 4'hb;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_HOLD = 2'b10} stretch_state_e;
endpackage : cs_stretch_pkg

// ---- core/e_stretch_timer.sv ----
`timescale 1ns/1ps
module e_stretch_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // internal e clock and current access
  input wire logic e_int,
  input wire logic access,
  input wire logic [1:0] cycles,
  // external e clock
  output logic ext_e,
  output logic busy
);
  cs_stretch_pkg::stretch_state_e state_r;
  cs_stretch_pkg::stretch_state_e state_nxt;
  logic e_prev_r;
  logic [1:0] remain_r;
  logic e_fall;

  assign e_fall = e_prev_r & ~e_int;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      e_prev_r <= 1'b0;
    end else begin
      e_prev_r <= e_int;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cs_stretch_pkg::ST_IDLE: begin
        if (e_fall && access && cycles != 2'h0) begin
          state_nxt = cs_stretch_pkg::ST_HOLD;
        end
      end
      cs_stretch_pkg::ST_HOLD: begin
        if (e_fall && remain_r == 2'h1) begin
          state_nxt = cs_stretch_pkg::ST_IDLE;
        end
      end
      default: state_nxt = cs_stretch_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= cs_stretch_pkg::ST_IDLE;
      remain_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == cs_stretch_pkg::ST_IDLE) begin
        remain_r <= cycles;
      end else if (e_fall) begin
        remain_r <= remain_r - 2'h1;
      end
    end
  end

  // only the pin is held; e_int keeps running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_e <= 1'b0;
      busy <= 1'b0;
    end else begin
      ext_e <= (state_nxt == cs_stretch_pkg::ST_HOLD) | e_int;
      busy <= state_nxt == cs_stretch_pkg::ST_HOLD;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_hold_e_high: assert property (busy |-> ext_e)
    else $error("external e low while stretching");
  a_no_zero_stretch: assert property (
    (state_r == cs_stretch_pkg::ST_IDLE && !(e_fall && access && cycles != 2'h0)) |=> !busy)
    else $error("stretch started without a stretched access");
endmodule : e_stretch_timer

// ---- core/chip_select_stretch_logic.sv ----
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// Function
// - msb of second select control has no storage, reads zero.
// - second-drives-program ORs second select onto program pin.
// - second polarity bit one gives active high, zero active low.
// - timing bit one valid whole address time, zero only e high.
// - size 0 disables; 1..9 give 2K up to 512K.
// - size 10/11 follow window 1/2; 12..15 behave as 512K.
// - start bits 18:11 compared above size; to 15 or 18 by follow.
// - only first select routes onto second, never the reverse.
// - routed select never asserts own pin; receiver covers all ranges.
// - routing keeps the select priority order for overlaps.
// - each select has zero to three stretch cycles, own range only.
// - stretch holds external e high whole periods, bus state kept.
// - only the external e is stretched, internal clocks run.
// - pair code A:B 00 none, 01 one, 10 two, 11 three.
// - stretch pairs io 7:6, first 5:4, second 3:2, program 1:0.
// - program stretch low bit resets to not special mode.
// - priority bit one puts general selects above program select.
// - first-drives-second ORs first and second onto second pin unless either drives-program bit is set.
// - first-drives-program ORs first select onto program pin.
module chip_select_stretch_logic (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // axi4-lite write
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // cpu bus
  input wire logic [18:0] cpu_addr,
  input wire logic addr_valid,
  input wire logic e_int,
  input wire logic window1_hit,
  input wire logic window2_hit,
  // strap
  input wire logic special_mode_flag,
  // first select, io select and program select settings held elsewhere
  input wire logic [7:0] first_select_base,
  input wire logic [3:0] first_select_size,
  input wire logic first_select_polarity,
  input wire logic first_select_timing,
  input wire logic first_drives_second,
  input wire logic first_drives_program,
  input wire logic first_expansion_follow,
  input wire logic io_select_enable,
  input wire logic io_select_polarity,
  input wire logic io_select_timing,
  input wire logic io_select_size,
  input wire logic program_select_enable,
  input wire logic [1:0] program_select_size,
  // select pins and external e
  output logic program_select,
  output logic first_general_select,
  output logic second_general_select,
  output logic io_select,
  output logic ext_e_clock,
  output logic stretch_active
);
  logic rst_meta_r;
  logic rst_n;
  logic special_mode_flag_meta_r;
  logic special_mode_flag_r;
  logic init_done_r;
  logic [7:0] select_stretch_config_r;
  logic [7:0] gp_select_two_base_r;
  logic [6:0] gp_select_two_control_r;
  logic [1:0] misc_r;
  logic aw_have_r;
  logic w_have_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic hit_io, hit_prog, hit_gp1, hit_gp2;
  logic win_io, win_prog, win_gp1, win_gp2;
  logic act_prog, act_gp1, act_gp2, act_io;
  logic [1:0] win_cycles;
  logic timer_ext_e, timer_busy;
  logic second_drives_program, second_select_polarity, second_select_timing;
  logic [3:0] second_select_size;
  logic select_priority_bit, second_expansion_follow;

  assign second_drives_program = gp_select_two_control_r[cs_stretch_pkg::CTL_DRV_PROG];
  assign second_select_polarity = gp_select_two_control_r[cs_stretch_pkg::CTL_POL];
  assign second_select_timing = gp_select_two_control_r[cs_stretch_pkg::CTL_TIMING];
  assign second_select_size = gp_select_two_control_r[cs_stretch_pkg::CTL_SIZE_LSB +: 4];
  assign select_priority_bit = misc_r[cs_stretch_pkg::MISC_PRIO];
  assign second_expansion_follow = misc_r[cs_stretch_pkg::MISC_FOLLOW];

  // reset release and strap synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // strap keeps sampling through reset so the first load after release sees it
  always_ff @(posedge clk) begin
    special_mode_flag_meta_r <= special_mode_flag;
    special_mode_flag_r <= special_mode_flag_meta_r;
  end

  // general select range match
  function automatic logic gp_hit(input logic [18:0] a, input logic [7:0] base,
                                  input logic [3:0] sz, input logic follow,
                                  input logic w1, input logic w2);
    logic hit;
    hit = 1'b1;
    if (sz == cs_stretch_pkg::SZ_OFF) begin
      hit = 1'b0;
    end else if (sz == cs_stretch_pkg::SZ_WIN1) begin
      hit = w1;
    end else if (sz == cs_stretch_pkg::SZ_WIN2) begin
      hit = w2;
    end else begin
      for (int j = 0; j < 8; j++) begin
        if ((j + 1) >= int'(sz) && (follow || j < 5) && a[11 + j] != base[j]) begin
          hit = 1'b0;
        end
      end
    end
    return hit;
  endfunction : gp_hit

  // qualify with address-valid or e-high time
  function automatic logic qual(input logic hit, input logic whole_time,
                                input logic av, input logic e);
    return hit & av & (whole_time | e);
  endfunction : qual

  always_comb begin
    hit_gp2 = qual(gp_hit(cpu_addr, gp_select_two_base_r, second_select_size,
                          second_expansion_follow, window1_hit, window2_hit),
                   second_select_timing, addr_valid, e_int);
    hit_gp1 = qual(gp_hit(cpu_addr, first_select_base, first_select_size,
                          first_expansion_follow, window1_hit, window2_hit),
                   first_select_timing, addr_valid, e_int);
    hit_prog = program_select_enable & addr_valid &
               (cpu_addr[15:13] >= (3'h7 << (3'h3 - {1'b0, program_select_size})));
    hit_io = qual(io_select_enable &
                  (io_select_size ? (cpu_addr[15:13] == 3'h0) : (cpu_addr[15:12] == 4'h1)),
                  io_select_timing, addr_valid, e_int);
  end

  always_comb begin
    win_io = hit_io;
    win_gp1 = hit_gp1 & ~hit_io & (select_priority_bit | ~hit_prog);
    win_gp2 = hit_gp2 & ~hit_io & ~hit_gp1 & (select_priority_bit | ~hit_prog);
    win_prog = hit_prog & ~hit_io & (~select_priority_bit | ~(hit_gp1 | hit_gp2));
  end

  // no path from second onto first
  // routed select never drives own pin
  always_comb begin
    act_prog = win_prog | (first_drives_program & win_gp1) |
               (second_drives_program & win_gp2);
    act_gp2 = ~second_drives_program &
              (win_gp2 | (first_drives_second & ~first_drives_program & win_gp1));
    act_gp1 = win_gp1 & ~first_drives_program &
              ~(first_drives_second & ~second_drives_program);
    act_io = win_io;
  end

  always_comb begin
    win_cycles = 2'h0;
    if (win_io) begin
      win_cycles = select_stretch_config_r[cs_stretch_pkg::STR_IO +: 2];
    end else if (win_prog) begin
      win_cycles = select_stretch_config_r[cs_stretch_pkg::STR_PROG +: 2];
    end else if (win_gp1) begin
      win_cycles = select_stretch_config_r[cs_stretch_pkg::STR_GP1 +: 2];
    end else if (win_gp2) begin
      win_cycles = select_stretch_config_r[cs_stretch_pkg::STR_GP2 +: 2];
    end
  end

  e_stretch_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .e_int(e_int),
    .access(win_io | win_prog | win_gp1 | win_gp2),
    .cycles(win_cycles),
    .ext_e(timer_ext_e),
    .busy(timer_busy)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_select <= 1'b1;
      first_general_select <= 1'b1;
      second_general_select <= 1'b1;
      io_select <= 1'b1;
    end else begin
      program_select <= ~act_prog;
      first_general_select <= act_gp1 ^ ~first_select_polarity;
      second_general_select <= act_gp2 ^ ~second_select_polarity;
      io_select <= act_io ^ ~io_select_polarity;
    end
  end

  assign ext_e_clock = timer_ext_e;
  assign stretch_active = timer_busy;

  // write path: address and data taken in either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      awready <= 1'b0;
      awaddr_r <= 12'h000;
    end else if (awvalid && awready) begin
      aw_have_r <= 1'b1;
      awready <= 1'b0;
      awaddr_r <= awaddr;
    end else if (bvalid && bready) begin
      aw_have_r <= 1'b0;
    end else if (!aw_have_r && !bvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_have_r <= 1'b0;
      wready <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (wvalid && wready) begin
      w_have_r <= 1'b1;
      wready <= 1'b0;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (bvalid && bready) begin
      w_have_r <= 1'b0;
    end else if (!w_have_r && !bvalid) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= cs_stretch_pkg::RESP_OKAY;
    end else if (aw_have_r && w_have_r && !bvalid) begin
      bvalid <= 1'b1;
      bresp <= mapped(awaddr_r) ? cs_stretch_pkg::RESP_OKAY : cs_stretch_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  function automatic logic mapped(input logic [11:0] a);
    return a == cs_stretch_pkg::ADDR_STRETCH || a == cs_stretch_pkg::ADDR_GP2_BASE ||
           a == cs_stretch_pkg::ADDR_GP2_CTRL || a == cs_stretch_pkg::ADDR_MISC ||
           a == cs_stretch_pkg::ADDR_STATUS;
  endfunction : mapped

  logic do_write;
  assign do_write = aw_have_r & w_have_r & ~bvalid & wstrb_r[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_done_r <= 1'b0;
      select_stretch_config_r <= cs_stretch_pkg::STR_RST;
    end else if (!init_done_r) begin
      init_done_r <= 1'b1;
      select_stretch_config_r[cs_stretch_pkg::STR_PROG] <= ~special_mode_flag_r;
    end else if (do_write && awaddr_r == cs_stretch_pkg::ADDR_STRETCH) begin
      select_stretch_config_r <= wdata_r[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gp_select_two_base_r <= cs_stretch_pkg::BASE_RST;
    end else if (do_write && awaddr_r == cs_stretch_pkg::ADDR_GP2_BASE) begin
      gp_select_two_base_r <= wdata_r[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gp_select_two_control_r <= cs_stretch_pkg::CTRL_RST;
    end else if (do_write && awaddr_r == cs_stretch_pkg::ADDR_GP2_CTRL) begin
      gp_select_two_control_r <= wdata_r[6:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      misc_r <= cs_stretch_pkg::MISC_RST;
    end else if (do_write && awaddr_r == cs_stretch_pkg::ADDR_MISC) begin
      misc_r <= wdata_r[1:0];
    end
  end

  // read path: one request at a time
  function automatic logic [31:0] reg_read(input logic [11:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      cs_stretch_pkg::ADDR_STRETCH: d[7:0] = select_stretch_config_r;
      cs_stretch_pkg::ADDR_GP2_BASE: d[7:0] = gp_select_two_base_r;
      cs_stretch_pkg::ADDR_GP2_CTRL: d[7:0] = {1'b0, gp_select_two_control_r};
      cs_stretch_pkg::ADDR_MISC: d[1:0] = misc_r;
      cs_stretch_pkg::ADDR_STATUS: d[5:0] = {timer_ext_e, win_gp2, win_gp1, win_prog,
                                             win_io, timer_busy};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : reg_read

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= cs_stretch_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= reg_read(araddr);
      rresp <= mapped(araddr) ? cs_stretch_pkg::RESP_OKAY : cs_stretch_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [11:0] rd_addr_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_r <= 12'h000;
    end else if (arvalid && arready) begin
      rd_addr_r <= araddr;
    end
  end

  a_ctrl_msb_zero: assert property (
    (rvalid && rd_addr_r == cs_stretch_pkg::ADDR_GP2_CTRL) |-> rdata[7] == 1'b0)
    else $error("control msb read as one");
  a_second_onto_prog: assert property (
    (second_drives_program && win_gp2) |=> (!program_select && second_general_select ==
                                            !$past(second_select_polarity)))
    else $error("second select not routed onto program pin");
  a_second_pol_high: assert property (
    (win_gp2 && !second_drives_program && second_select_polarity) |=> second_general_select)
    else $error("active high second select not asserted");
  a_second_e_gate: assert property (
    (!second_select_timing && !e_int && !first_drives_second)
      |=> second_general_select == !$past(second_select_polarity))
    else $error("second select asserted outside e high");
  a_second_disabled: assert property (
    (second_select_size == cs_stretch_pkg::SZ_OFF && !first_drives_second)
      |=> second_general_select == !$past(second_select_polarity))
    else $error("disabled second select asserted");
  a_first_routed_off: assert property (
    first_drives_program |=> first_general_select == !$past(first_select_polarity))
    else $error("routed first select drove own pin");
  a_prog_priority: assert property (
    (hit_prog && hit_gp1 && !hit_io) |-> (win_prog == !select_priority_bit &&
                                          win_gp1 == select_priority_bit))
    else $error("program and general priority wrong");
  a_strap_reset: assert property (
    $rose(init_done_r) |-> select_stretch_config_r ==
      {7'h00, !$past(special_mode_flag_r)})
    else $error("program stretch reset value wrong");
endmodule : chip_select_stretch_logic

// ---- verification/ext_bus_device.sv ----
`timescale 1ns/1ps
// slow peripheral on the expansion bus: it sees its select pins and the
// external e clock and reports how long each e high phase lasted
module ext_bus_device (
  // clock
  input wire logic clk,
  // bus side
  input wire logic ext_e_clock,
  input wire logic program_select,
  input wire logic second_general_select,
  // observation
  output logic [7:0] e_high_len,
  output logic [7:0] prog_hits
);
  logic [7:0] run_r;
  initial begin
    run_r = 8'h00;
    e_high_len = 8'h00;
    prog_hits = 8'h00;
  end
  // the length is latched on the fall so a stretched phase is seen whole
  always @(posedge clk) begin
    if (ext_e_clock) begin
      run_r <= run_r + 8'h01;
    end else if (run_r != 8'h00) begin
      e_high_len <= run_r;
      run_r <= 8'h00;
    end
    if (!program_select) begin
      prog_hits <= prog_hits + 8'h01;
    end
  end
endmodule : ext_bus_device

// ---- verification/chip_select_stretch_logic_test.sv ----
`timescale 1ns/1ps
module chip_select_stretch_logic_test;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [3:0] wstrb;
  logic [1:0] rsp;
  logic [18:0] cpu_addr;
  logic addr_valid, e_int, f_drv2;
  logic [2:0] e_cnt;
  logic [7:0] f_base;
  logic [7:0] e_len, p_hits;
  logic strap, w1, f_pol, f_tim, f_drvp, io_en, p_en;
  logic [3:0] f_size;
  logic [1:0] p_size;
  wire awready, wready, bvalid, arready, rvalid, pgm, gp1, gp2, ios, ext_e, sact;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int n_mismatch, checks_done, cycles;
  chip_select_stretch_logic i_chip_select_stretch_logic (.clk(clk), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .cpu_addr(cpu_addr), .addr_valid(addr_valid),
    .e_int(e_int), .window1_hit(w1), .window2_hit(1'b0), .special_mode_flag(strap),
    .first_select_base(f_base), .first_select_size(f_size), .first_select_polarity(f_pol),
    .first_select_timing(f_tim), .first_drives_second(f_drv2), .first_drives_program(f_drvp),
    .first_expansion_follow(1'b0), .io_select_enable(io_en), .io_select_polarity(1'b0),
    .io_select_timing(1'b1), .io_select_size(1'b0), .program_select_enable(p_en),
    .program_select_size(p_size), .program_select(pgm), .first_general_select(gp1),
    .second_general_select(gp2), .io_select(ios), .ext_e_clock(ext_e), .stretch_active(sact));
  ext_bus_device i_ext_bus_device (.clk(clk), .ext_e_clock(ext_e), .program_select(pgm),
    .second_general_select(gp2), .e_high_len(e_len), .prog_hits(p_hits));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // internal e runs free: four clocks high, four low
  always @(posedge clk) begin
    e_cnt <= e_cnt + 3'h1;
    e_int <= e_cnt[2];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rdreg(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rdreg
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle
  task automatic t_regs();
    rdreg(cs_stretch_pkg::ADDR_STRETCH);
    check(rd, 32'h0000_0001);
    rdreg(cs_stretch_pkg::ADDR_GP2_CTRL);
    check(rd, 32'h0000_0000);
    wr(cs_stretch_pkg::ADDR_GP2_CTRL, 8'hff);
    rdreg(cs_stretch_pkg::ADDR_GP2_CTRL);
    check(rd, 32'h0000_007f);
    wr(cs_stretch_pkg::ADDR_STRETCH, 8'hb4);
    check({30'h0, rsp}, {30'h0, cs_stretch_pkg::RESP_OKAY});
    rdreg(cs_stretch_pkg::ADDR_STRETCH);
    check(rd, 32'h0000_00b4);
    rdreg(12'hffc);
    check({30'h0, rsp}, {30'h0, cs_stretch_pkg::RESP_SLVERR});
    wr(12'hffc, 8'h5a);
    check({30'h0, rsp}, {30'h0, cs_stretch_pkg::RESP_SLVERR});
    $display("test regs done");
  endtask : t_regs
  task automatic t_decode();
    wr(cs_stretch_pkg::ADDR_STRETCH, 8'h00);
    wr(cs_stretch_pkg::ADDR_GP2_BASE, 8'h05);
    wr(cs_stretch_pkg::ADDR_GP2_CTRL, 8'h31);
    cpu_addr <= 19'h02900;
    settle();
    check({31'h0, gp2}, 32'h1);
    cpu_addr <= 19'h03000;
    settle();
    check({31'h0, gp2}, 32'h0);
    cpu_addr <= 19'h02900;
    wr(cs_stretch_pkg::ADDR_GP2_CTRL, 8'h11);
    settle();
    check({31'h0, gp2}, 32'h0);
    wr(cs_stretch_pkg::ADDR_GP2_CTRL, 8'h21);
    @(negedge e_int);
    settle();
    check({31'h0, gp2}, 32'h0);
    wr(cs_stretch_pkg::ADDR_GP2_CTRL, 8'h3a);
    cpu_addr <= 19'h03000;
    w1 <= 1'b1;
    settle();
    check({31'h0, gp2}, 32'h1);
    w1 <= 1'b0;
    settle();
    check({31'h0, gp2}, 32'h0);
    wr(cs_stretch_pkg::ADDR_GP2_CTRL, 8'h31);
    cpu_addr <= 19'h12900;
    settle();
    check({31'h0, gp2}, 32'h1);
    wr(cs_stretch_pkg::ADDR_MISC, 8'h02);
    settle();
    check({31'h0, gp2}, 32'h0);
    wr(cs_stretch_pkg::ADDR_MISC, 8'h00);
    $display("test decode done");
  endtask : t_decode
  task automatic t_route();
    wr(cs_stretch_pkg::ADDR_GP2_CTRL, 8'h71);
    settle();
    check({30'h0, gp2, pgm}, 32'h0);
    wr(cs_stretch_pkg::ADDR_GP2_CTRL, 8'h31);
    f_drv2 <= 1'b1;
    cpu_addr <= 19'h08100;
    settle();
    check({30'h0, gp1, gp2}, 32'h1);
    f_drvp <= 1'b1;
    settle();
    check({29'h0, gp1, gp2, pgm}, 32'h0);
    {f_drv2, f_drvp, p_size} <= 4'h1;
    settle();
    check({30'h0, gp1, pgm}, 32'h0);
    wr(cs_stretch_pkg::ADDR_MISC, 8'h01);
    settle();
    check({30'h0, gp1, pgm}, 32'h3);
    // program covers the whole map; io still wins
    {p_size, io_en} <= 3'h1;
    cpu_addr <= 19'h01000;
    settle();
    check({30'h0, ios, pgm}, 32'h1);
    {p_size, io_en} <= 3'h6;
    $display("test route done");
  endtask : t_route
  task automatic t_stretch();
    cpu_addr <= 19'h02900;
    for (int n = 0; n < 4; n++) begin
      wr(cs_stretch_pkg::ADDR_STRETCH, {4'h0, n[1:0], 2'b00});
      repeat (80) @(posedge clk);
      check({24'h0, e_len}, 32'd4 + 32'd8 * n);
      // the first e fall after the pin drops always starts from idle
      @(negedge ext_e);
      @(negedge e_int);
      repeat (2) @(posedge clk);
      check({31'h0, sact}, {31'h0, n != 0});
    end
    // out of range: no stretch even with three cycles set
    cpu_addr <= 19'h03000;
    repeat (80) @(posedge clk);
    check({24'h0, e_len}, 32'd4);
    @(negedge ext_e);
    @(negedge e_int);
    repeat (2) @(posedge clk);
    check({31'h0, sact}, 32'h0);
    $display("test stretch done");
  endtask : t_stretch
  task automatic t_strap();
    strap <= 1'b1;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    check({26'h0, pgm, gp1, gp2, ios, ext_e, sact}, 32'h3c);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rdreg(cs_stretch_pkg::ADDR_STRETCH);
    check(rd, 32'h0000_0000);
    rdreg(cs_stretch_pkg::ADDR_GP2_CTRL);
    check(rd, 32'h0000_0000);
    $display("test strap done");
  endtask : t_strap
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, addr_valid, f_drv2} = 8'h0;
    {awaddr, araddr, wdata, cpu_addr, e_cnt, e_int, f_base} = '0;
    wstrb = 4'h1;
    f_base = 8'h10;
    {f_size, f_pol, f_tim, p_en, p_size} = 9'h03f;
    {strap, w1, f_drvp, io_en} = 4'h0;
    n_mismatch = 0;
    checks_done = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    addr_valid <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_decode();
    t_route();
    t_stretch();
    t_strap();
    conclude();
  end
endmodule : chip_select_stretch_logic_test
